/* core/gpio_map.svh */
// Constants of the programmable I/O port block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the selector interface.
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

`define NUM_PINS 32
`define NUM_FUNC 23
`define FN_GPIO 5'h00
`define FN_ANALOG 5'h01
`define FN_MAX 5'h16
`define CFG_W 10
`define CFG_FN_LSB 0
`define CFG_FN_MSB 4
`define CFG_DIR_LSB 8
`define CFG_DIR_MSB 9
`define CFG_MASK 10'h31F
`define CFG_RESET 10'h000
`define OUT_RESET 32'h0000_0000
`define REG_W 16
`define CFG_BASE 8'h00
`define PORT_BASE 8'h20
`define PORT_END 8'h2F
`define REG_DATA 2'h0
`define REG_SET 2'h1
`define REG_CLR 2'h2
`define SWD_CLK_PIN 12
`define SWD_IO_PIN 13
`define ADC_PINS 4
`define QUAD_CHANS 3
`define QUAD_PAIRS 12

`endif

/* core/gpio_pkg.sv */
// Types of the programmable I/O port block.
// Assumes the constants header is on the include path.
package gpio_pkg;
`include "gpio_map.svh"

	typedef enum logic [1:0] {DIR_IN, DIR_PULL_UP, DIR_PULL_DOWN, DIR_OUT} pin_dir_e;
	typedef logic [`CFG_W-1:0] pin_cfg_t;

	typedef struct packed {
		logic [`NUM_PINS-1:0][`CFG_W-1:0] cfg;
		logic [`NUM_PINS-1:0] out_latch;
		logic [`REG_W-1:0] rd_data;
		logic [`NUM_PINS-1:0] pin_o;
		logic [`NUM_PINS-1:0] pin_oe;
		logic [`NUM_PINS-1:0] pull_up;
		logic [`NUM_PINS-1:0] pull_down;
		logic [`NUM_FUNC-1:0] periph_in;
		logic [`ADC_PINS-1:0] adc_link;
		logic [`QUAD_CHANS-1:0] quad_a;
		logic [`QUAD_CHANS-1:0] quad_b;
		logic swd_clk;
		logic swdio_in;
	} port_state_s;
endpackage

/* core/pin_input_select.sv */
// Priority selector feeding each peripheral input from one pin.
// Assumes codes of pins that must not feed inputs arrive as zero.
`timescale 1ns/1ps
`default_nettype none
module pin_input_select (
	pin_select_if.select_side sb
);
	import gpio_pkg::*;

	// Scan from the top pin down so the lowest matching pin is kept
	always_comb begin
		sb.sel = '0;
		for (int k = 1; k < `NUM_FUNC; k++) begin
			for (int i = `NUM_PINS - 1; i >= 0; i--) begin
				if (sb.code[i] == 5'(k)) begin
					sb.sel[k] = sb.level[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* core/pin_select_if.sv */
// Carrier between the port block and its input priority selector.
// Assumes the package is compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.svh"
interface pin_select_if;
	logic [`NUM_PINS-1:0][4:0] code;
	logic [`NUM_PINS-1:0] level;
	logic [`NUM_FUNC-1:0] sel;
	modport port_side (output code, output level, input sel);
	modport select_side (input code, input level, output sel);
endinterface
`default_nettype wire

/* core/programmable_io_port_mux.sv */
// Programmable I/O port block: pin function multiplexer and port registers.
// Assumes pin levels and strobes synchronous to sys_clk_i.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module programmable_io_port_mux (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic [31:0] pin_i,
	output logic [31:0] pin_o,
	output logic [31:0] pin_oe_o,
	output logic [31:0] pull_up_o,
	output logic [31:0] pull_down_o,
	input wire logic [22:0] periph_out_i,
	output logic [22:0] periph_in_o,
	output logic [3:0] adc_link_o,
	input wire logic [11:0] decoder_channel_pin_select_i,
	output logic [2:0] decoder_phase_a_o,
	output logic [2:0] decoder_phase_b_o,
	input wire logic debug_port_enable_i,
	input wire logic swdio_out_i,
	input wire logic swdio_oe_i,
	output logic swd_clk_o,
	output logic swdio_in_o,
	input wire logic sleep_i
);
	import gpio_pkg::*;

	port_state_s st;
	port_state_s nx;
	logic [`NUM_PINS-1:0] ana_mask;
	pin_select_if sb ();

	// Analog select counts only on the four converter pins
	function automatic logic is_analog(pin_cfg_t c, int i);
		return (c[`CFG_FN_MSB:`CFG_FN_LSB] == `FN_ANALOG) && (i < `ADC_PINS);
	endfunction

	// Place a port's bits into the flat pin vector
	function automatic logic [31:0] expand(logic [1:0] p, logic [15:0] w);
		case (p)
			2'h0: return {24'h00_0000, w[7:0]};
			2'h1: return {18'h0_0000, w[5:0], 8'h00};
			2'h2: return {8'h00, w[9:0], 14'h0000};
			default: return {w[7:0], 24'h00_0000};
		endcase
	endfunction

	// Gather a port's bits, upper bits zero
	function automatic logic [15:0] gather(logic [1:0] p, logic [31:0] v);
		case (p)
			2'h0: return {8'h00, v[7:0]};
			2'h1: return {10'h000, v[13:8]};
			2'h2: return {6'h00, v[23:14]};
			default: return {8'h00, v[31:24]};
		endcase
	endfunction

	// Pick the pin pair of one decoder channel; zero selects none
	function automatic logic [1:0] pair_pick(logic [31:0] v, logic [3:0] s);
		logic [1:0] r;
		r = 2'b00;
		for (int k = 1; k <= `QUAD_PAIRS; k++) begin
			if (s == 4'(k)) begin
				r = {v[2 * k - 1], v[2 * k - 2]};
			end
		end
		return r;
	endfunction

	// Inputs to the selector and the analog read mask
	always_comb begin
		for (int i = 0; i < `NUM_PINS; i++) begin
			ana_mask[i] = is_analog(st.cfg[i], i);
			if (ana_mask[i] || (debug_port_enable_i && (i == `SWD_CLK_PIN || i == `SWD_IO_PIN))) begin
				sb.code[i] = `FN_GPIO;
			end else begin
				sb.code[i] = st.cfg[i][`CFG_FN_MSB:`CFG_FN_LSB];
			end
		end
		sb.level = pin_i;
	end

	pin_input_select u_sel (
		.sb(sb.select_side)
	);

	// Next state: register file, pin drivers, peripheral routing
	always_comb begin
		logic [4:0] code;
		pin_dir_e dir;
		logic ana;
		logic val;
		logic [1:0] port;
		logic [31:0] wmask;
		code = `FN_GPIO;
		dir = DIR_IN;
		ana = 1'b0;
		val = 1'b0;
		port = addr_i[3:2];
		wmask = expand(port, wdata_i);
		nx = st;
		nx.rd_data = 16'h0000;
		// Register writes
		if (wr_i) begin
			if (addr_i < `PORT_BASE) begin
				nx.cfg[addr_i[4:0]] = wdata_i[`CFG_W-1:0] & `CFG_MASK;
			end else if (addr_i <= `PORT_END && addr_i[1:0] == `REG_DATA) begin
				nx.out_latch = (st.out_latch & ~expand(port, 16'hFFFF)) | wmask;
			end else if (addr_i <= `PORT_END && addr_i[1:0] == `REG_SET) begin
				nx.out_latch = st.out_latch | wmask;
			end else if (addr_i <= `PORT_END && addr_i[1:0] == `REG_CLR) begin
				nx.out_latch = st.out_latch & ~wmask;
			end
		end
		// Register reads; set and clear read as zero
		if (rd_i) begin
			if (addr_i < `PORT_BASE) begin
				nx.rd_data = {6'h00, st.cfg[addr_i[4:0]]};
			end else if (addr_i <= `PORT_END && addr_i[1:0] == `REG_DATA) begin
				nx.rd_data = gather(port, pin_i & ~ana_mask);
			end
		end
		// Pin drivers, held during sleep
		for (int i = 0; i < `NUM_PINS; i++) begin
			code = st.cfg[i][`CFG_FN_MSB:`CFG_FN_LSB];
			dir = pin_dir_e'(st.cfg[i][`CFG_DIR_MSB:`CFG_DIR_LSB]);
			ana = is_analog(st.cfg[i], i);
			if (code == `FN_GPIO || code > `FN_MAX) begin
				val = st.out_latch[i];
			end else begin
				val = periph_out_i[code];
			end
			if (!sleep_i) begin
				nx.pin_oe[i] = (dir == DIR_OUT) && !ana;
				nx.pin_o[i] = val;
				nx.pull_up[i] = (dir == DIR_PULL_UP) && !ana;
				nx.pull_down[i] = (dir == DIR_PULL_DOWN) && !ana;
				if (debug_port_enable_i && i == `SWD_CLK_PIN) begin
					nx.pin_oe[i] = 1'b0;
					nx.pin_o[i] = 1'b0;
					nx.pull_up[i] = 1'b0;
					nx.pull_down[i] = 1'b0;
				end else if (debug_port_enable_i && i == `SWD_IO_PIN) begin
					nx.pin_oe[i] = swdio_oe_i;
					nx.pin_o[i] = swdio_out_i;
					nx.pull_up[i] = 1'b0;
					nx.pull_down[i] = 1'b0;
				end
			end
		end
		// Peripheral side
		nx.periph_in = sb.sel;
		nx.adc_link = ana_mask[`ADC_PINS-1:0];
		for (int c = 0; c < `QUAD_CHANS; c++) begin
			{nx.quad_b[c], nx.quad_a[c]} = pair_pick(pin_i, decoder_channel_pin_select_i[4 * c +: 4]);
		end
		nx.swd_clk = debug_port_enable_i & pin_i[`SWD_CLK_PIN];
		nx.swdio_in = debug_port_enable_i & pin_i[`SWD_IO_PIN];
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st <= '0;
			st.cfg <= {`NUM_PINS{`CFG_RESET}};
			st.out_latch <= `OUT_RESET;
		end else begin
			st <= nx;
		end
	end

	// Outputs straight from the state register
	assign rdata_o = st.rd_data;
	assign pin_o = st.pin_o;
	assign pin_oe_o = st.pin_oe;
	assign pull_up_o = st.pull_up;
	assign pull_down_o = st.pull_down;
	assign periph_in_o = st.periph_in;
	assign adc_link_o = st.adc_link;
	assign decoder_phase_a_o = st.quad_a;
	assign decoder_phase_b_o = st.quad_b;
	assign swd_clk_o = st.swd_clk;
	assign swdio_in_o = st.swdio_in;

	// Checks of the pin and register behaviour
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	pull_off_a: assert property ((pull_up_o & pin_oe_o) == 0 && (pull_down_o & pin_oe_o) == 0)
		else $error("pull active on driven pin");
	dir_out_a: assert property (!sleep_i && st.cfg[6][9:8] == 2'b11 |=> pin_oe_o[6])
		else $error("output direction not driven");
	dir_pull_a: assert property (!sleep_i && st.cfg[6][9:8] == 2'b01 |=> pull_up_o[6] && !pin_oe_o[6])
		else $error("pull-up direction wrong");
	set_bit_a: assert property (wr_i && addr_i == 8'h21 && wdata_i[4] |=> st.out_latch[4])
		else $error("set write lost");
	clr_keep_a: assert property (wr_i && addr_i == 8'h22 && !wdata_i[3] && st.out_latch[3] |=> st.out_latch[3])
		else $error("clear zero bit changed latch");
	data_write_a: assert property (wr_i && addr_i == 8'h28 |=> st.out_latch[23:14] == $past(wdata_i[9:0]))
		else $error("data write not stored");
	read_data_a: assert property (rd_i && addr_i == 8'h20 |=> rdata_o == {8'h00, $past(pin_i[7:0] & ~ana_mask[7:0])})
		else $error("port read mismatch");
	gpio_drive_a: assert property (!sleep_i && st.cfg[25] == 10'h300 ##1 !sleep_i |=> pin_o[25] == $past(st.out_latch[25]) && pin_oe_o[25])
		else $error("plain port bit not driven from latch");
	sleep_hold_a: assert property (sleep_i |=> $stable(pin_o) && $stable(pin_oe_o) && $stable(pull_up_o))
		else $error("pin changed in sleep");
	prio_low_a: assert property (sb.code[3] == 5'h05 && sb.code[9] == 5'h05 |=> periph_in_o[5] == $past(pin_i[3]))
		else $error("input priority wrong");
	swd_map_a: assert property (debug_port_enable_i |=> swd_clk_o == $past(pin_i[12]) && !pull_up_o[12])
		else $error("debug clock not mapped");
	quad_pair_a: assert property (decoder_channel_pin_select_i[3:0] == 4'h2 |=> decoder_phase_a_o[0] == $past(pin_i[2]) && decoder_phase_b_o[0] == $past(pin_i[3]))
		else $error("decoder pair wrong");
	adc_link_a: assert property (st.cfg[1][4:0] != `FN_ANALOG |=> !adc_link_o[1])
		else $error("converter linked without analog select");

	gpio_toggle_c: cover property (wr_i && addr_i == 8'h21 ##1 wr_i && addr_i == 8'h22);
	sleep_entry_c: cover property (!sleep_i ##1 sleep_i [*3]);
	shared_input_c: cover property (sb.code[0] == 5'h07 && sb.code[30] == 5'h07);
	analog_read_c: cover property (ana_mask[0] && rd_i && addr_i == 8'h20);
endmodule
`default_nettype wire

/* verification/pin_peer.sv */
// Pad model for the port block: block drive, outside driver, pull, else float.
// Assumes one clock shared with the block; outside levels come from the bench.
`timescale 1ns/1ps
`default_nettype none
module pin_peer (
	input wire logic clk_i,
	input wire logic [31:0] drive_i,
	input wire logic [31:0] en_i,
	input wire logic [31:0] pu_i,
	input wire logic [31:0] pd_i,
	input wire logic [31:0] ext_val_i,
	input wire logic [31:0] ext_en_i,
	output logic [31:0] level_o
);
	logic flip = 1'b0;
	// Floating pads change every cycle so no stale level reads back
	always @(posedge clk_i) begin
		flip <= ~flip;
	end
	// Resolve each pad
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (en_i[i]) level_o[i] = drive_i[i];
			else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
			else if (pu_i[i]) level_o[i] = 1'b1;
			else if (pd_i[i]) level_o[i] = 1'b0;
			else level_o[i] = flip;
		end
	end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Bench for the programmable I/O port block: register bus, pads, peripherals.
// Assumes the design files and pin_peer are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk_i, reset_i, wr_i, rd_i, dbg, sw_o, sw_oe, sleep;
	logic [7:0] addr;
	logic [15:0] wdata, rdata;
	logic [31:0] pin_i, pin_o, oe, pu, pd, ext, ext_en;
	logic [22:0] pout, per;
	logic [11:0] qsel;
	logic [3:0] adc;
	logic [2:0] qa, qb;
	logic sw_clk, sw_in;
	int err_total, total_checks, cyc;
	// Block and its pads
	programmable_io_port_mux dut_u (.sys_clk_i, .reset_i, .addr_i(addr), .wdata_i(wdata), .wr_i, .rd_i,
		.rdata_o(rdata), .pin_i, .pin_o, .pin_oe_o(oe), .pull_up_o(pu), .pull_down_o(pd), .periph_out_i(pout),
		.periph_in_o(per), .adc_link_o(adc), .decoder_channel_pin_select_i(qsel), .decoder_phase_a_o(qa),
		.decoder_phase_b_o(qb), .debug_port_enable_i(dbg), .swdio_out_i(sw_o), .swdio_oe_i(sw_oe),
		.swd_clk_o(sw_clk), .swdio_in_o(sw_in), .sleep_i(sleep));
	pin_peer peer_u (.clk_i(sys_clk_i), .drive_i(pin_o), .en_i(oe), .pu_i(pu), .pd_i(pd), .ext_val_i(ext),
		.ext_en_i(ext_en), .level_o(pin_i));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic settle;
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask
	// One write cycle, or two back to back when b is set
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit b = 0);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk_i);
		if (b) addr <= 8'h20;
		if (b) wdata <= 16'h0000;
		if (b) @(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 chk(32'(rdata), 32'(e));
	endtask
	task automatic drv(input logic [31:0] v);
		@(posedge sys_clk_i);
		ext <= v;
		ext_en <= 32'hFFFF_FFFF;
		settle();
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Plain port bit: data, set, clear and latest write wins
	task automatic t_gpio;
		chk(oe | pu | pd, 32'h0000_0000);
		wr(8'h19, 16'h0300);
		wr(8'h04, 16'h0300);
		wr(8'h20, 16'h0010);
		settle();
		chk(pin_o & oe & 32'h0000_0010, 32'h0000_0010);
		wr(8'h22, 16'h0010);
		settle();
		chk(pin_o & 32'h0000_0010, 32'h0000_0000);
		wr(8'h21, 16'h0010);
		wr(8'h22, 16'h0000);
		settle();
		chk(pin_o & 32'h0000_0010, 32'h0000_0010);
		wr(8'h21, 16'h0010, 1);
		settle();
		chk(pin_o & 32'h0000_0010, 32'h0000_0000);
	endtask
	// Register map, reads of pad levels and port widths
	task automatic t_regs;
		wr(8'h05, 16'hFFFF);
		rd(8'h05, 16'h031F);
		wr(8'h23, 16'hFFFF);
		rd(8'h23, 16'h0000);
		wr(8'h28, 16'h0155);
		rd(8'h21, 16'h0000);
		wr(8'h05, 16'h0000);
		wr(8'h01, 16'h0001);
		wr(8'h20, 16'h0010);
		drv(32'h0000_00A7);
		rd(8'h20, 16'h00B5);
		drv(32'hFFFF_FFFF);
		rd(8'h24, 16'h003F);
		rd(8'h28, 16'h03FF);
		rd(8'h2C, 16'h00FD);
	endtask
	// Direction codes, pulls, analog links
	task automatic t_dir;
		logic [2:0] exp [4] = '{3'b000, 3'b010, 3'b001, 3'b100};
		for (int d = 0; d < 4; d++) begin
			wr(8'h06, 16'(d) << 8);
			settle();
			chk(32'({oe[6], pu[6], pd[6]}), 32'(exp[d]));
		end
		wr(8'h00, 16'h0101);
		settle();
		chk(32'({pu[0], adc}), 32'h0000_0003);
	endtask
	// Peripheral routing, priority and decoder pins
	task automatic t_periph;
		wr(8'h03, 16'h0005);
		wr(8'h09, 16'h0005);
		wr(8'h0A, 16'h0016);
		drv(32'h0000_0600);
		chk(32'(per) & 32'h0040_0020, 32'h0040_0000);
		drv(32'h0000_0008);
		chk(32'(per) & 32'h0040_0020, 32'h0000_0020);
		wr(8'h0B, 16'h0307);
		pout <= 23'h00_0080;
		settle();
		chk(pin_o & oe & 32'h0000_0800, 32'h0000_0800);
		qsel <= 12'h002;
		drv(32'h0000_0004);
		chk(32'({qa[0], qb[0]}), 32'h0000_0002);
	endtask
	// Debug pins, then sleep holding pad drivers
	task automatic t_hold;
		dbg <= 1'b1;
		sw_oe <= 1'b1;
		sw_o <= 1'b1;
		drv(32'h0000_1000);
		chk(32'({sw_clk, pin_o[13], oe[13], oe[12]}), 32'h0000_000E);
		wr(8'h21, 16'h0010);
		sleep <= 1'b1;
		wr(8'h22, 16'h0010);
		wr(8'h04, 16'h0000);
		settle();
		chk(pin_o & oe & 32'h0000_0010, 32'h0000_0010);
		sleep <= 1'b0;
		settle();
		chk(oe & 32'h0000_0010, 32'h0000_0000);
	endtask
	// Clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Hang guard
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			print_verdict();
		end
	end
	// Reset, then the scenarios
	initial begin
		reset_i = 1'b1;
		{wr_i, rd_i, dbg, sw_o, sw_oe, sleep} = 6'h00;
		{addr, wdata, ext, ext_en, pout, qsel} = 123'h0;
		repeat (6) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_gpio();
		t_regs();
		t_dir();
		t_periph();
		t_hold();
		print_verdict();
	end
endmodule
`default_nettype wire
